// *** core/crc_checker_pkg.sv ***
`default_nettype none
package crc_checker_pkg;

    // Checker datapath
    localparam int          SIG_W          = 32;
    localparam logic [31:0] CRC_POLY       = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT       = 32'hFFFFFFFF;
    localparam logic [31:0] SIG_CLEAR      = 32'h00000000;

    // Configuration memory walk
    localparam int          ADDR_W         = 10;
    localparam logic [9:0]  ADDR_FIRST     = 10'h000;
    localparam logic [9:0]  ADDR_LAST      = 10'h3FF;
    localparam logic [9:0]  ADDR_STEP      = 10'h001;

    // Check clock divider, ratio 2**n with n = 0..8
    localparam int          DIV_EXP_W      = 4;
    localparam logic [3:0]  DIV_EXP_MAX    = 4'h8;
    localparam int          DIV_CNT_W      = 8;
    localparam logic [7:0]  DIV_CNT_STEP   = 8'h01;
    localparam int          OSC_FREQ_HZ    = 80000000;
    localparam int          CHK_MIN_HZ     = OSC_FREQ_HZ / 256;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_RUN    = 2'b01,
        PH_FINISH = 2'b11
    } phase_t;

    // Asynchronous pins, all synchronised before use
    typedef struct packed {
        logic userMode;
        logic configDone;
        logic edEnable;
        logic overrideInstr;
        logic shiftDr;
        logic tck;
        logic tdi;
    } pins_t;

    typedef struct packed {
        logic integrityFault;
        logic checkActive;
        logic tdo;
    } status_t;

    typedef struct packed {
        phase_t             phase;
        pins_t              syncA;
        pins_t              syncB;
        logic               tckPrev;
        logic               cfgDonePrev;
        logic [SIG_W-1:0]   checkWord;
        logic [SIG_W-1:0]   crcAcc;
        logic [SIG_W-1:0]   signature;
        logic               fault;
        logic               active;
        logic               tdo;
        logic [ADDR_W-1:0]  addr;
    } checker_state_t;

    typedef struct packed {
        logic [DIV_CNT_W-1:0] count;
        logic                 tick;
    } divider_state_t;

    localparam checker_state_t CHECKER_RESET = '0;
    localparam divider_state_t DIVIDER_RESET = '0;

    // One 32-bit word folded into the running CRC, MSB first
    function automatic logic [31:0] crc32_word(input logic [31:0] crc, input logic [31:0] data);
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Low n bits set; exponent above the limit is clamped
    function automatic logic [7:0] div_mask(input logic [3:0] exp);
        logic [3:0] e;
        e = (exp > DIV_EXP_MAX) ? DIV_EXP_MAX : exp;
        return 8'((9'h001 << e) - 9'h001);
    endfunction

endpackage
`default_nettype wire

// *** core/check_clock_divider.sv ***
`default_nettype none
module check_clock_divider (
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    input  wire logic [crc_checker_pkg::DIV_EXP_W-1:0] divExp,
    output var  logic                                 tick
);
    import crc_checker_pkg::*;

    divider_state_t s;
    divider_state_t next_s;
    logic [DIV_CNT_W-1:0] mask;

    assign mask = div_mask(divExp);

    always_comb begin
        next_s       = s;
        next_s.count = s.count + DIV_CNT_STEP;
        // One tick every 2**n cycles, n = 0 gives every cycle
        next_s.tick  = ((s.count & mask) == mask);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= DIVIDER_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule
`default_nettype wire

// *** core/config_memory_crc_checker.sv ***
// Behaviour
// - A 32-bit signature register holds the computed CRC compared with the stored one and is zero when all is well.
// - Any non-zero signature means the configuration memory cells are corrupted.
// - The integrity fault flag is derived from the signature register.
// - The pre-computed 32-bit check word is loaded into the storage register when configuration ends.
// - In user mode the stored check word feeds the compute-and-compare step that decides on an error.
// - Under the check-word override instruction the storage register is a 32-bit scan chain that can be rewritten.
// - Checking keeps running while the override instruction is in use.
// - With detection enabled, checking starts by itself on entering user mode.
// - The fault flag stays low until a finished pass shows corruption, then goes high.
// - A raised flag holds through the next pass and reflects only the latest result.
// - The flag goes low when a new pass finishes clean.
// - Checking repeats without end until reset.
// - The checker is paced by a divided clock that caps its rate.
// - The divider is 2 to the power n with n from 0 to 8.
`default_nettype none
module config_memory_crc_checker (
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    input  wire crc_checker_pkg::pins_t               pinsAsync,
    input  wire logic [crc_checker_pkg::DIV_EXP_W-1:0] divExp,
    input  wire logic [crc_checker_pkg::SIG_W-1:0]     precomputedIn,
    input  wire logic [crc_checker_pkg::SIG_W-1:0]     cfgData,
    output var  logic [crc_checker_pkg::ADDR_W-1:0]    cfgAddr,
    output var  logic [crc_checker_pkg::SIG_W-1:0]     signatureOut,
    output var  crc_checker_pkg::status_t             status
);
    import crc_checker_pkg::*;

    checker_state_t   s;
    checker_state_t   next_s;
    logic             tick;
    logic             cfgDoneRise;
    logic             scanShift;
    logic             startReq;
    logic [SIG_W-1:0] compareWord;

    // Any set bit in a result word counts as corruption
    function automatic logic sig_nonzero(input logic [SIG_W-1:0] w);
        return (w != SIG_CLEAR);
    endfunction

    check_clock_divider u_divider (
        .clk_sys (clk_sys),
        .rst     (rst),
        .divExp  (divExp),
        .tick    (tick)
    );

    // Edge detectors look only at the second stage
    assign cfgDoneRise = s.syncB.configDone & ~s.cfgDonePrev;
    assign scanShift   = s.syncB.overrideInstr & s.syncB.shiftDr & s.syncB.tck & ~s.tckPrev;
    assign startReq    = s.syncB.userMode & s.syncB.edEnable;
    // Zero exactly when memory matches the stored check word
    assign compareWord = s.crcAcc ^ s.checkWord;

    always_comb begin
        next_s             = s;
        next_s.syncA       = pinsAsync;
        next_s.syncB       = s.syncA;
        next_s.tckPrev     = s.syncB.tck;
        next_s.cfgDonePrev = s.syncB.configDone;

        // Load wins over a shift landing in the same cycle
        if (cfgDoneRise) begin
            next_s.checkWord = precomputedIn;
        end else if (scanShift) begin
            next_s.checkWord = {s.syncB.tdi, s.checkWord[SIG_W-1:1]};
            next_s.tdo       = s.checkWord[0];
        end

        // Scan path above is independent, so the walk never pauses
        unique case (s.phase)
            PH_IDLE: begin
                if (startReq) begin
                    next_s.phase  = PH_RUN;
                    next_s.crcAcc = CRC_INIT;
                    next_s.addr   = ADDR_FIRST;
                    next_s.active = 1'b1;
                end
            end
            PH_RUN: begin
                if (tick) begin
                    next_s.crcAcc = crc32_word(s.crcAcc, cfgData);
                    next_s.addr   = s.addr + ADDR_STEP;
                    if (s.addr == ADDR_LAST) begin
                        next_s.phase = PH_FINISH;
                    end
                end
            end
            PH_FINISH: begin
                next_s.signature = compareWord;
                // Flag follows the newest pass only
                next_s.fault     = sig_nonzero(compareWord);
                next_s.phase     = PH_RUN;
                next_s.crcAcc    = CRC_INIT;
                next_s.addr      = ADDR_FIRST;
            end
            default: begin
                next_s.phase = PH_IDLE;
            end
        endcase
    end

    // Reset drops everything to idle with the flag low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= CHECKER_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign cfgAddr               = s.addr;
    assign signatureOut          = s.signature;
    assign status                = '{
        integrityFault: s.fault,
        checkActive:    s.active,
        tdo:            s.tdo
    };

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_FAULT_FROM_SIGNATURE: assert property (
        status.integrityFault == (signatureOut != SIG_CLEAR)
    ) else $error("Fault flag disagrees with signature");

    AST_LOAD_AT_CFG_END: assert property (
        cfgDoneRise |=> (s.checkWord == $past(precomputedIn))
    ) else $error("Check word not loaded at configuration end");

    AST_SCAN_SHIFT: assert property (
        (scanShift && !cfgDoneRise) |=>
            (s.checkWord[SIG_W-1] == $past(s.syncB.tdi)) &&
            (s.checkWord[SIG_W-2:0] == $past(s.checkWord[SIG_W-1:1])) &&
            (status.tdo == $past(s.checkWord[0]))
    ) else $error("Scan chain did not shift by one");

    AST_NO_HALT_IN_SCAN: assert property (
        (scanShift && s.phase == PH_RUN && tick) |=> (cfgAddr != $past(cfgAddr))
    ) else $error("Walk stalled during override scan");

    AST_AUTO_START: assert property (
        (s.phase == PH_IDLE && startReq) |=>
            (s.phase == PH_RUN) && (cfgAddr == ADDR_FIRST) && status.checkActive
    ) else $error("Checking did not start in user mode");

    AST_FAULT_SET: assert property (
        (s.phase == PH_FINISH && compareWord != SIG_CLEAR) |=> status.integrityFault
    ) else $error("Corrupt pass did not raise the flag");

    AST_FAULT_HOLD: assert property (
        (s.phase != PH_FINISH) |=> $stable(status.integrityFault)
    ) else $error("Flag moved in the middle of a pass");

    AST_FAULT_CLEAR: assert property (
        (s.phase == PH_FINISH && compareWord == SIG_CLEAR) |=>
            !status.integrityFault && (signatureOut == SIG_CLEAR)
    ) else $error("Clean pass did not drop the flag");

    AST_REPEAT: assert property (
        (s.phase == PH_FINISH) |=> (s.phase == PH_RUN) && (cfgAddr == ADDR_FIRST)
    ) else $error("Checking did not restart after a pass");

    AST_PACED_BY_TICK: assert property (
        (s.phase == PH_RUN && !tick) |=> $stable(cfgAddr) && $stable(s.crcAcc)
    ) else $error("Walk advanced without a divider tick");

    AST_IDLE_CLEAN: assert property (
        (s.phase == PH_IDLE) |-> (!status.integrityFault && !status.checkActive)
    ) else $error("Idle checker shows fault or activity");

    AST_SIG_UPDATE: assert property (
        (s.phase == PH_FINISH) |=> (signatureOut == $past(compareWord))
    ) else $error("Signature not taken at pass end");

    AST_NONZERO_IS_FAULT: assert property (
        (s.phase == PH_FINISH) |=>
            (status.integrityFault == ($past(compareWord) != SIG_CLEAR))
    ) else $error("Flag does not match the pass result");

    AST_SIG_HOLD: assert property (
        (s.phase != PH_FINISH) |=> $stable(signatureOut)
    ) else $error("Signature moved in the middle of a pass");

    AST_SIG_CHANGE_AT_END: assert property (
        $changed(signatureOut) |-> $past(s.phase == PH_FINISH)
    ) else $error("Signature changed outside a pass end");

    AST_FLAG_RISE_AT_END: assert property (
        $rose(status.integrityFault) |-> $past(s.phase == PH_FINISH)
    ) else $error("Flag rose outside a pass end");

    AST_FLAG_FALL_AT_END: assert property (
        $fell(status.integrityFault) |-> $past(s.phase == PH_FINISH)
    ) else $error("Flag fell outside a pass end");

    AST_START_CRC_INIT: assert property (
        (s.phase == PH_IDLE && startReq) |=> (s.crcAcc == CRC_INIT)
    ) else $error("First pass did not start from the initial CRC");

    AST_STAY_IDLE: assert property (
        (s.phase == PH_IDLE && !startReq) |=>
            (s.phase == PH_IDLE) && !status.checkActive
    ) else $error("Checking started without user mode and enable");

    AST_IDLE_NO_WALK: assert property (
        (s.phase == PH_IDLE && !startReq) |=>
            $stable(cfgAddr) && $stable(s.crcAcc)
    ) else $error("Walk moved while idle");

    AST_IDLE_AT_ORIGIN: assert property (
        (s.phase == PH_IDLE) |-> (cfgAddr == ADDR_FIRST) && (signatureOut == SIG_CLEAR)
    ) else $error("Idle checker not at its reset point");

    AST_ACTIVE_RISE: assert property (
        $rose(status.checkActive) |-> $past(startReq)
    ) else $error("Activity rose without a start request");

    AST_ACTIVE_STICKY: assert property (
        status.checkActive |=> status.checkActive
    ) else $error("Checking stopped without reset");

    AST_ACTIVE_RUNNING: assert property (
        status.checkActive |-> (s.phase != PH_IDLE)
    ) else $error("Active flag set while idle");

    AST_ONCE_STARTED: assert property (
        (s.phase != PH_IDLE) |=> (s.phase != PH_IDLE)
    ) else $error("Checker fell back to idle without reset");

    AST_LEGAL_PHASE: assert property (
        (s.phase == PH_IDLE) || (s.phase == PH_RUN) ||
            (s.phase == PH_FINISH)
    ) else $error("Illegal phase code");

    AST_RUN_CONTINUES: assert property (
        (s.phase == PH_RUN && !(tick && cfgAddr == ADDR_LAST)) |=> (s.phase == PH_RUN)
    ) else $error("Walk left the run phase early");

    AST_WALK_STEP: assert property (
        (s.phase == PH_RUN && tick) |=>
            (cfgAddr == $past(cfgAddr) + ADDR_STEP)
    ) else $error("Address did not step on a divider tick");

    AST_CRC_FOLD: assert property (
        (s.phase == PH_RUN && tick) |=>
            (s.crcAcc == crc32_word($past(s.crcAcc), $past(cfgData)))
    ) else $error("Memory word not folded into the CRC");

    AST_PASS_WRAP: assert property (
        (s.phase == PH_RUN && tick && cfgAddr == ADDR_LAST) |=>
            (s.phase == PH_FINISH) && (cfgAddr == ADDR_FIRST)
    ) else $error("Pass did not end after the last word");

    AST_FINISH_AT_ORIGIN: assert property (
        (s.phase == PH_FINISH) |-> (cfgAddr == ADDR_FIRST)
    ) else $error("Pass end not at the first address");

    AST_CRC_REINIT: assert property (
        (s.phase == PH_FINISH) |=> (s.crcAcc == CRC_INIT)
    ) else $error("CRC not restarted for the next pass");

    AST_WORD_STILL: assert property (
        (!scanShift && !cfgDoneRise) |=>
            $stable(s.checkWord) && $stable(status.tdo)
    ) else $error("Check word moved without load or shift");

    AST_NO_SCAN_WITHOUT_INSTR: assert property (
        (!s.syncB.overrideInstr && !cfgDoneRise) |=> $stable(s.checkWord)
    ) else $error("Check word shifted without the override instruction");

    AST_WORD_CHANGE_CAUSE: assert property (
        $changed(s.checkWord) |-> $past(cfgDoneRise || scanShift)
    ) else $error("Check word changed with no cause");

    AST_TICK_N0: assert property (
        (divExp == 4'h0) |=> tick
    ) else $error("Ratio one did not tick every cycle");

    // Free-running count reaches all ones every 256 cycles
    AST_TICK_GAP: assert property (
        tick |-> ##[1:256] tick
    ) else $error("Divider gap longer than the largest ratio");

    AST_TDO_HOLD: assert property (
        !scanShift |=> $stable(status.tdo)
    ) else $error("Scan output moved without a shift");

    AST_SCAN_KEEPS_WALK: assert property (
        (s.syncB.overrideInstr && s.phase == PH_RUN && tick) |=>
            (cfgAddr == $past(cfgAddr) + ADDR_STEP)
    ) else $error("Walk paused under the override instruction");

    AST_START_AT_ORIGIN: assert property (
        $rose(status.checkActive) |-> (s.phase == PH_RUN) && (cfgAddr == ADDR_FIRST)
    ) else $error("Checking did not begin at the first address");

    AST_FAULT_NEEDS_PASS: assert property (
        status.integrityFault |-> status.checkActive
    ) else $error("Flag raised before any pass ran");

endmodule
`default_nettype wire

// *** dv/cfg_mem_model.sv ***
`default_nettype none
module cfg_mem_model (
    input  wire logic [crc_checker_pkg::ADDR_W-1:0] cfgAddr,
    input  wire logic [crc_checker_pkg::ADDR_W-1:0] badAddr,
    input  wire logic                               badEn,
    output var  logic [crc_checker_pkg::SIG_W-1:0]  cfgData
);
    timeunit 1ns;
    timeprecision 1ns;
    import crc_checker_pkg::*;
    // One flipped bit stands in for a single upset cell
    always_comb begin
        cfgData = 32'(cfgAddr) * 32'h9E3779B1;
        if (badEn && cfgAddr == badAddr) begin
            cfgData = cfgData ^ 32'h00000100;
        end
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import crc_checker_pkg::*;
    logic        clk_sys      = 1'b0;
    logic        rst          = 1'b1;
    pins_t       pins         = '0;
    logic [3:0]  divExp       = 4'h0;
    logic [31:0] word         = 32'h0;
    logic [31:0] newWord;
    logic [9:0]  badAddr      = 10'h000;
    logic        badEn        = 1'b0;
    logic [31:0] cfgData;
    logic [31:0] sig;
    logic [9:0]  cfgAddr;
    logic [9:0]  a;
    status_t     status;
    int          errors       = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    int          k;

    config_memory_crc_checker dut_u (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .pinsAsync     (pins),
        .divExp        (divExp),
        .precomputedIn (word),
        .cfgData       (cfgData),
        .cfgAddr       (cfgAddr),
        .signatureOut  (sig),
        .status        (status)
    );
    cfg_mem_model mem_u (
        .cfgAddr (cfgAddr),
        .badAddr (badAddr),
        .badEn   (badEn),
        .cfgData (cfgData)
    );

    always #20 clk_sys = ~clk_sys;

    function automatic logic [31:0] passCrc(input logic bad);
        logic [31:0] c;
        logic [31:0] d;
        c = CRC_INIT;
        for (int n = 0; n < 1024; n++) begin
            d = 32'(n) * 32'h9E3779B1;
            if (bad && n == badAddr) begin
                d = d ^ 32'h00000100;
            end
            for (int i = 31; i >= 0; i--) begin
                c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
            end
        end
        return c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Returns once the finished pass has updated the result
    task automatic passEnd;
        @(negedge clk_sys iff cfgAddr === ADDR_LAST);
        @(negedge clk_sys iff cfgAddr === ADDR_FIRST);
        tick(1);
    endtask

    // tck is held 3+ cycles per level to clear the pin synchronisers
    task automatic scan(input logic [31:0] w, input logic en);
        pins.overrideInstr = en;
        pins.shiftDr = 1'b1;
        for (int i = 0; i < 32; i++) begin
            pins.tdi = w[i];
            tick(3);
            pins.tck = 1'b1;
            tick(4);
            check(32'(status.tdo), en ? 32'(word[i]) : 32'h0);
            pins.tck = 1'b0;
        end
        pins.overrideInstr = 1'b0;
        pins.shiftDr = 1'b0;
    endtask

    task automatic conclude;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(95698));
        tick(16);
        check(sig, SIG_CLEAR);
        check(32'(status), 32'h0);
        rst = 1'b0;
        word = passCrc(1'b0);
        pins.configDone = 1'b1;
        pins.edEnable = 1'b1;
        pins.userMode = 1'b1;
        tick(4);
        check(32'(status.checkActive), 32'h1);
        passEnd();
        check(32'(cfgAddr), 32'(ADDR_FIRST));
        check(sig, SIG_CLEAR);
        check(32'(status.integrityFault), 32'h0);
        $display("start test done");
        badAddr = 10'(10 + $urandom % 1014);
        badEn = 1'b1;
        passEnd();
        badEn = 1'b0;
        check(sig, passCrc(1'b1) ^ word);
        check(32'(status.integrityFault), 32'h1);
        @(negedge clk_sys iff cfgAddr === 10'h200);
        check(32'(status.integrityFault), 32'h1);
        passEnd();
        check(sig, SIG_CLEAR);
        check(32'(status.integrityFault), 32'h0);
        $display("upset test done");
        newWord = $urandom;
        scan(newWord, 1'b0);
        passEnd();
        check(sig, SIG_CLEAR);
        scan(newWord, 1'b1);
        passEnd();
        check(sig, passCrc(1'b0) ^ newWord);
        check(32'(status.integrityFault), 32'h1);
        $display("scan test done");
        rst = 1'b1;
        pins.userMode = 1'b0;
        pins.edEnable = 1'b0;
        tick(2);
        check(32'(status), 32'h0);
        check(sig, SIG_CLEAR);
        rst = 1'b0;
        tick(10);
        check(32'(status.checkActive), 32'h0);
        pins.userMode = 1'b1;
        tick(6);
        check(32'(status.checkActive), 32'h0);
        pins.edEnable = 1'b1;
        tick(4);
        check(32'(status.checkActive), 32'h1);
        $display("reset test done");
        for (int n = 0; n < 10; n++) begin
            divExp = 4'(n);
            // First step after a change may still be paced by the old ratio
            repeat (2) begin
                a = cfgAddr;
                @(negedge clk_sys iff (cfgAddr !== a && cfgAddr > 10'h001));
            end
            a = cfgAddr;
            k = 0;
            while (cfgAddr === a) begin
                tick(1);
                k++;
            end
            check(32'(k), 32'(1 << (n > 8 ? 8 : n)));
        end
        $display("divider test done");
        conclude();
    end
endmodule
`default_nettype wire
